// ===== logic/atm_aux_sel.sv
`timescale 1ns/100ps
module atm_aux_sel import atm_pkg::*; (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic [3:0] sel_i,
  input wire atm_analog_t ana_i,
  input wire atm_digital_t dig_i,
  input wire logic test_bus_bit_i,
  output atm_aux_t aux_o
);
  atm_aux_t aux_d;
  logic [DAC_W:0] iq_sum;

  // combined samples averaged to keep DAC range
  assign iq_sum = {1'b0, ana_i.adc_i} + {1'b0, ana_i.adc_q};

  // decode the selector
  always_comb begin
    aux_d = '{pin: 1'b0, oe_n: 1'b0, dac_en: 1'b0, dac: '0};
    unique case (sel_i)
      SEL_TRISTATE: aux_d.oe_n = 1'b1; // R2
      SEL_DAC_REG: aux_d.dac = ana_i.dac_test_value; // R1
      SEL_CORR_ONE: aux_d.dac = ana_i.correlator_signal_one; // R1
      SEL_CORR_TWO: aux_d.dac = ana_i.correlator_signal_two; // R1
      SEL_MIN_LEVEL: aux_d.dac = ana_i.minimum_level_signal; // R1
      SEL_ADC_I: aux_d.dac = ana_i.adc_i; // R1
      SEL_ADC_Q: aux_d.dac = ana_i.adc_q; // R1
      SEL_ADC_IQ: aux_d.dac = iq_sum[DAC_W:1]; // R1
      SEL_PROD_TEST: aux_d.pin = dig_i.prod_test; // R2
      SEL_SM_CLK: aux_d.pin = dig_i.secure_module_clk; // R2
      SEL_HIGH: aux_d.pin = 1'b1; // R2
      SEL_LOW: aux_d.pin = 1'b0; // R2
      SEL_TX_ACTIVE: aux_d.pin = dig_i.transmitter_active; // R2
      SEL_RX_ACTIVE: aux_d.pin = dig_i.receiver_active; // R2
      SEL_SUBCARRIER: aux_d.pin = dig_i.subcarrier_detected; // R2
      SEL_TEST_BUS: aux_d.pin = test_bus_bit_i; // R2
    endcase
    if (sel_i != SEL_TRISTATE && sel_i <= SEL_ADC_IQ) begin
      aux_d.dac_en = 1'b1; // R1
      aux_d.oe_n = 1'b1;
    end
  end

  // registered output
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      aux_o <= '{pin: 1'b0, oe_n: 1'b1, dac_en: 1'b0, dac: '0};
    end else begin
      aux_o <= aux_d;
    end
  end
endmodule

// ===== logic/atm_pkg.sv
// Functional notes
// R1: codes 1 to 7 put the test register value, correlator one, correlator two, minimum level, in-phase sample, quadrature sample or both samples on the output's DAC.
// R2: code 0 tristates the output; codes 8 to 15 give production test, secure-module clock, high, low, transmitter active, receiver active, subcarrier detected and the test-bus bit.
// R3: two independent selectors, one per test output pin, each pin following only its own.
// R4: with pseudo-random mode on, a 9-stage or 15-stage sequence is generated as configured.
// R5: the pattern is emitted only after the send command; until then nothing goes out.
// R6: preamble, sync byte, start bit and parity bits are inserted by the device per the selected mode.
// R7: the host sets every transmit setting before entering pseudo-random mode.
// R8: the test-bus select field picks the group of internal signals seen on the test bus.
// R9: generators use x^9+x^5+1 and x^15+x^14+1, seeded nonzero on entry to test mode.
package atm_pkg;
  localparam logic [3:0] SEL_TRISTATE = 4'h0;
  localparam logic [3:0] SEL_DAC_REG = 4'h1;
  localparam logic [3:0] SEL_CORR_ONE = 4'h2;
  localparam logic [3:0] SEL_CORR_TWO = 4'h3;
  localparam logic [3:0] SEL_MIN_LEVEL = 4'h4;
  localparam logic [3:0] SEL_ADC_I = 4'h5;
  localparam logic [3:0] SEL_ADC_Q = 4'h6;
  localparam logic [3:0] SEL_ADC_IQ = 4'h7;
  localparam logic [3:0] SEL_PROD_TEST = 4'h8;
  localparam logic [3:0] SEL_SM_CLK = 4'h9;
  localparam logic [3:0] SEL_HIGH = 4'hA;
  localparam logic [3:0] SEL_LOW = 4'hB;
  localparam logic [3:0] SEL_TX_ACTIVE = 4'hC;
  localparam logic [3:0] SEL_RX_ACTIVE = 4'hD;
  localparam logic [3:0] SEL_SUBCARRIER = 4'hE;
  localparam logic [3:0] SEL_TEST_BUS = 4'hF;
  localparam int DAC_W = 6;
  localparam int TBUS_W = 7;
  localparam logic [14:0] PRBS_SEED = 15'h7FFF;
  localparam int PRBS9_TAP_A = 8;
  localparam int PRBS9_TAP_B = 4;
  localparam int PRBS15_TAP_A = 14;
  localparam int PRBS15_TAP_B = 13;
  localparam logic [7:0] SYNC_A = 8'hB2;
  localparam logic [7:0] SYNC_B = 8'h4D;
  localparam logic [3:0] PRE_BYTES_FRAMED = 4'h6;
  localparam logic [2:0] LAST_BIT = 3'h7;
  // analog-side sources offered to the DACs
  typedef struct packed {
    logic [DAC_W-1:0] dac_test_value;
    logic [DAC_W-1:0] correlator_signal_one;
    logic [DAC_W-1:0] correlator_signal_two;
    logic [DAC_W-1:0] minimum_level_signal;
    logic [DAC_W-1:0] adc_i;
    logic [DAC_W-1:0] adc_q;
  } atm_analog_t;
  // digital status sources
  typedef struct packed {
    logic prod_test;
    logic secure_module_clk;
    logic transmitter_active;
    logic receiver_active;
    logic subcarrier_detected;
  } atm_digital_t;
  // framing modes of the transmitter
  typedef enum logic [1:0] {
    MODE_RAW,
    MODE_PARITY,
    MODE_SYNC
  } atm_mode_t;
  // one output pin with its DAC
  typedef struct packed {
    logic pin;
    logic oe_n;
    logic dac_en;
    logic [DAC_W-1:0] dac;
  } atm_aux_t;
endpackage

// ===== logic/atm_top.sv
`timescale 1ns/100ps
module atm_top import atm_pkg::*; (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic [3:0] first_output_source_select_i,
  input wire logic [3:0] second_output_source_select_i,
  input wire atm_analog_t analog_i,
  input wire atm_digital_t digital_raw_i,
  input wire logic [2:0] test_bus_select_i,
  input wire logic [TBUS_W-1:0] test_bus_group0_i,
  input wire logic [TBUS_W-1:0] test_bus_group1_i,
  input wire logic [TBUS_W-1:0] test_bus_group2_i,
  input wire logic [TBUS_W-1:0] test_bus_group3_i,
  input wire logic prbs_enable_i,
  input wire logic prbs_long_i,
  input wire atm_mode_t tx_mode_i,
  input wire logic send_cmd_i,
  output atm_aux_t test_output_pin_one_o,
  output atm_aux_t test_output_pin_two_o,
  output logic [TBUS_W-1:0] test_bus_o,
  output logic tx_data_o,
  output logic tx_valid_o
);
  //////////////////////////////////////////////////////////////////////////
  // synchronisers for asynchronous digital sources
  atm_digital_t dig_s1_q;
  atm_digital_t dig_s2_q;
  logic send_s1_q;
  logic send_s2_q;

  // two flops before use
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      dig_s1_q <= '0;
      dig_s2_q <= '0;
      send_s1_q <= 1'b0;
      send_s2_q <= 1'b0;
    end else begin
      dig_s1_q <= digital_raw_i;
      dig_s2_q <= dig_s1_q;
      send_s1_q <= send_cmd_i;
      send_s2_q <= send_s1_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // test bus group select
  logic [TBUS_W-1:0] test_bus_d;
  logic [TBUS_W-1:0] test_bus_q;

  // choose the signal group on the bus
  always_comb begin
    unique case (test_bus_select_i[1:0]) // R8
      2'h0: test_bus_d = test_bus_group0_i;
      2'h1: test_bus_d = test_bus_group1_i;
      2'h2: test_bus_d = test_bus_group2_i;
      2'h3: test_bus_d = test_bus_group3_i;
    endcase
    if (test_bus_select_i[2]) begin
      test_bus_d = '0; // unused groups read zero
    end
  end

  // register the bus
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      test_bus_q <= '0;
    end else begin
      test_bus_q <= test_bus_d; // R8
    end
  end
  assign test_bus_o = test_bus_q;

  //////////////////////////////////////////////////////////////////////////
  // two independent output selectors
  atm_aux_sel u_aux_one (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .sel_i(first_output_source_select_i), // R3
    .ana_i(analog_i),
    .dig_i(dig_s2_q),
    .test_bus_bit_i(test_bus_q[0]),
    .aux_o(test_output_pin_one_o)
  );

  atm_aux_sel u_aux_two (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .sel_i(second_output_source_select_i), // R3
    .ana_i(analog_i),
    .dig_i(dig_s2_q),
    .test_bus_bit_i(test_bus_q[0]),
    .aux_o(test_output_pin_two_o)
  );

  //////////////////////////////////////////////////////////////////////////
  // pseudo-random generator
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PREAMBLE,
    ST_SYNC,
    ST_START,
    ST_DATA,
    ST_PARITY
  } atm_state_t;

  atm_state_t state_q;
  logic [14:0] lfsr_q;
  logic en_q;
  logic long_q;
  atm_mode_t mode_q;
  logic [3:0] byte_cnt_q;
  logic [2:0] bit_cnt_q;
  logic par_q;
  logic prbs_bit;
  logic fb;
  logic tx_data_q;
  logic tx_valid_q;

  // feedback taps of the two polynomials
  assign fb = long_q ? (lfsr_q[PRBS15_TAP_A] ^ lfsr_q[PRBS15_TAP_B]) // R9
                     : (lfsr_q[PRBS9_TAP_A] ^ lfsr_q[PRBS9_TAP_B]); // R9
  assign prbs_bit = long_q ? lfsr_q[PRBS15_TAP_A] : lfsr_q[PRBS9_TAP_A];

  // enable edge and settings captured on entry
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      en_q <= 1'b0;
      long_q <= 1'b0;
      mode_q <= MODE_RAW;
    end else begin
      en_q <= prbs_enable_i;
      if (prbs_enable_i && !en_q) begin
        long_q <= prbs_long_i; // R4
        mode_q <= tx_mode_i; // R7
      end
    end
  end

  // lfsr steps only while data bits go out
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      lfsr_q <= PRBS_SEED;
    end else if (prbs_enable_i && !en_q) begin
      lfsr_q <= PRBS_SEED; // R9
    end else if (state_q == ST_DATA) begin
      lfsr_q <= {lfsr_q[13:0], fb}; // R4
    end
  end

  // framing sequencer
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= ST_IDLE;
      byte_cnt_q <= '0;
      bit_cnt_q <= '0;
      par_q <= 1'b0;
    end else if (!en_q || !send_s2_q) begin
      state_q <= ST_IDLE; // R5
      byte_cnt_q <= '0;
      bit_cnt_q <= '0;
      par_q <= 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          bit_cnt_q <= '0;
          byte_cnt_q <= '0;
          unique case (mode_q) // R6
            MODE_SYNC: state_q <= ST_PREAMBLE;
            MODE_PARITY: state_q <= ST_START;
            default: state_q <= ST_DATA;
          endcase
        end
        ST_PREAMBLE: begin
          bit_cnt_q <= bit_cnt_q + 3'h1;
          if (bit_cnt_q == LAST_BIT) begin
            byte_cnt_q <= byte_cnt_q + 4'h1;
            if (byte_cnt_q == PRE_BYTES_FRAMED - 4'h1) begin
              byte_cnt_q <= '0;
              state_q <= ST_SYNC; // R6
            end
          end
        end
        ST_SYNC: begin
          bit_cnt_q <= bit_cnt_q + 3'h1;
          if (bit_cnt_q == LAST_BIT) begin
            byte_cnt_q <= byte_cnt_q + 4'h1;
            if (byte_cnt_q == 4'h1) begin
              state_q <= ST_DATA; // R6
            end
          end
        end
        ST_START: begin
          par_q <= 1'b1;
          bit_cnt_q <= '0;
          state_q <= ST_DATA; // R6
        end
        ST_DATA: begin
          bit_cnt_q <= bit_cnt_q + 3'h1;
          par_q <= par_q ^ prbs_bit;
          if (bit_cnt_q == LAST_BIT && mode_q == MODE_PARITY) begin
            state_q <= ST_PARITY; // R6
          end
        end
        ST_PARITY: begin
          state_q <= ST_START;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // serial output bit per state
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tx_data_q <= 1'b0;
      tx_valid_q <= 1'b0;
    end else begin
      tx_valid_q <= (state_q != ST_IDLE); // R5
      unique case (state_q)
        ST_PREAMBLE: tx_data_q <= 1'b0; // R6
        ST_SYNC: tx_data_q <= byte_cnt_q[0] ? SYNC_B[LAST_BIT - bit_cnt_q]
                                            : SYNC_A[LAST_BIT - bit_cnt_q]; // R6
        ST_START: tx_data_q <= 1'b0; // R6
        ST_DATA: tx_data_q <= prbs_bit; // R4
        ST_PARITY: tx_data_q <= par_q; // R6
        default: tx_data_q <= 1'b0;
      endcase
    end
  end
  assign tx_data_o = tx_data_q;
  assign tx_valid_o = tx_valid_q;
endmodule

// ===== tb/atm_top_assertions.sv
`timescale 1ns/100ps
module atm_top_assertions import atm_pkg::*; (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic [3:0] first_output_source_select_i,
  input wire logic [3:0] second_output_source_select_i,
  input wire atm_analog_t analog_i,
  input wire logic [2:0] test_bus_select_i,
  input wire logic [TBUS_W-1:0] test_bus_group1_i,
  input wire logic prbs_enable_i,
  input wire logic send_cmd_i,
  input wire atm_aux_t test_output_pin_one_o,
  input wire atm_aux_t test_output_pin_two_o,
  input wire logic [TBUS_W-1:0] test_bus_o,
  input wire logic tx_valid_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  ////////////////////////////////////////////////////////////////////////////////
  // selector codes seen one cycle later at the pins
  a_tristate_one: assert property (
    first_output_source_select_i == SEL_TRISTATE |=>
    test_output_pin_one_o.oe_n && !test_output_pin_one_o.dac_en)
    else $error("pin one not released for code zero");
  a_high_one: assert property (
    first_output_source_select_i == SEL_HIGH |=>
    test_output_pin_one_o.pin && !test_output_pin_one_o.oe_n)
    else $error("pin one not high");
  a_low_two: assert property (
    second_output_source_select_i == SEL_LOW |=>
    !test_output_pin_two_o.pin && !test_output_pin_two_o.oe_n)
    else $error("pin two not low");
  a_dac_register: assert property (
    first_output_source_select_i == SEL_DAC_REG |=> test_output_pin_one_o.dac_en &&
    test_output_pin_one_o.dac == $past(analog_i.dac_test_value))
    else $error("pin one dac not the test value");
  a_dac_combined: assert property (
    second_output_source_select_i == SEL_ADC_IQ |=> test_output_pin_two_o.dac ==
    6'((7'($past(analog_i.adc_i)) + 7'($past(analog_i.adc_q))) >> 1))
    else $error("pin two dac not the combined sample");
  ////////////////////////////////////////////////////////////////////////////////
  // test bus group choice
  a_bus_group: assert property (
    test_bus_select_i == 3'h1 |=> test_bus_o == $past(test_bus_group1_i))
    else $error("test bus not group one");
  a_bus_empty: assert property (
    test_bus_select_i[2] |=> test_bus_o == '0)
    else $error("test bus not zero");
  ////////////////////////////////////////////////////////////////////////////////
  // no pattern without send command and mode
  a_send_quiet: assert property (
    !send_cmd_i [*6] |-> !tx_valid_o)
    else $error("pattern without send");
  a_mode_quiet: assert property (
    !prbs_enable_i [*4] |-> !tx_valid_o)
    else $error("pattern without test mode");
endmodule
bind atm_top atm_top_assertions atm_top_assertions_inst (
  .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .analog_i(analog_i),
  .first_output_source_select_i(first_output_source_select_i),
  .second_output_source_select_i(second_output_source_select_i),
  .test_bus_select_i(test_bus_select_i), .test_bus_group1_i(test_bus_group1_i),
  .prbs_enable_i(prbs_enable_i), .send_cmd_i(send_cmd_i), .tx_valid_o(tx_valid_o),
  .test_output_pin_one_o(test_output_pin_one_o), .test_bus_o(test_bus_o),
  .test_output_pin_two_o(test_output_pin_two_o));

// ===== tb/atm_top_tb.sv
`timescale 1ns/100ps
module atm_top_tb import atm_pkg::*;;
  typedef struct packed {
    logic [3:0] sel;
    logic oe_n;
    logic dac_en;
    logic [5:0] dac;
    logic pin;
    logic care;
  } atm_row_t;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [3:0] sel_one, sel_two;
  atm_analog_t analog;
  atm_digital_t digital;
  logic [2:0] bus_sel;
  logic [TBUS_W-1:0] grp [4];
  logic prbs_en, prbs_long, send, tx_data, tx_valid;
  atm_mode_t mode;
  atm_aux_t pin_one, pin_two;
  logic [TBUS_W-1:0] bus;
  atm_row_t rows [16];
  logic [63:0] bits;
  logic [15:0] sync_word;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  ////////////////////////////////////////////////////////////////////////////////
  atm_top atm_top_inst (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .first_output_source_select_i(sel_one),
    .second_output_source_select_i(sel_two), .analog_i(analog), .digital_raw_i(digital),
    .test_bus_select_i(bus_sel), .test_bus_group0_i(grp[0]), .test_bus_group1_i(grp[1]),
    .test_bus_group2_i(grp[2]), .test_bus_group3_i(grp[3]), .prbs_enable_i(prbs_en),
    .prbs_long_i(prbs_long), .tx_mode_i(mode), .send_cmd_i(send),
    .test_output_pin_one_o(pin_one), .test_output_pin_two_o(pin_two),
    .test_bus_o(bus), .tx_data_o(tx_data), .tx_valid_o(tx_valid));
  // clock and hang guard
  always #12.5 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      mismatches++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // compare, wait and verdict helpers
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic check_pin(input atm_aux_t p, input atm_row_t r);
    check(16'(p.oe_n), 16'(r.oe_n));
    check(16'(p.dac_en), 16'(r.dac_en));
    if (r.dac_en) check(16'(p.dac), 16'(r.dac));
    if (r.care) check(16'(p.pin), 16'(r.pin));
  endtask
  task automatic results();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // enter test mode with fresh settings, then send and collect n bits
  task automatic run_prbs(input atm_mode_t m, input logic lng, input int n);
    @(posedge ref_clk_i);
    prbs_en <= 1'b0;
    send <= 1'b0;
    mode <= m;
    prbs_long <= lng;
    settle(6);
    @(posedge ref_clk_i);
    prbs_en <= 1'b1;
    settle(8);
    check(16'(tx_valid), 16'h0000);
    @(posedge ref_clk_i);
    send <= 1'b1;
    bits = '0;
    for (int w = 0; w < 20 && tx_valid !== 1'b1; w++) settle(1);
    for (int i = 0; i < n; i++) begin
      bits[i] = tx_data;
      check(16'(tx_valid), 16'h0001);
      settle(1);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    // fixed sources and expected pin per code
    analog = {6'h11, 6'h22, 6'h33, 6'h0C, 6'h3F, 6'h21};
    digital = 5'b10101;
    grp = '{7'h55, 7'h2A, 7'h0F, 7'h70};
    {sel_one, sel_two, bus_sel, prbs_en, prbs_long, send, mode} = '0;
    sync_word = {SYNC_A, SYNC_B};
    rows = '{{4'h0, 2'b10, 6'h00, 2'b00}, {4'h1, 2'b11, 6'h11, 2'b00},
      {4'h2, 2'b11, 6'h22, 2'b00}, {4'h3, 2'b11, 6'h33, 2'b00},
      {4'h4, 2'b11, 6'h0C, 2'b00}, {4'h5, 2'b11, 6'h3F, 2'b00},
      {4'h6, 2'b11, 6'h21, 2'b00}, {4'h7, 2'b11, 6'h30, 2'b00},
      {4'h8, 2'b00, 6'h00, 2'b11}, {4'h9, 2'b00, 6'h00, 2'b01},
      {4'hA, 2'b00, 6'h00, 2'b11}, {4'hB, 2'b00, 6'h00, 2'b01},
      {4'hC, 2'b00, 6'h00, 2'b11}, {4'hD, 2'b00, 6'h00, 2'b01},
      {4'hE, 2'b00, 6'h00, 2'b11}, {4'hF, 2'b00, 6'h00, 2'b11}};
    repeat (8) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    // every code on both pins at once, different codes per pin
    for (int k = 0; k < 16; k++) begin
      @(posedge ref_clk_i);
      sel_one <= rows[k].sel;
      sel_two <= rows[15-k].sel;
      settle(6);
      check_pin(pin_one, rows[k]);
      check_pin(pin_two, rows[15-k]);
    end
    // inverted digital sources through the sync stage, pin one per code
    @(posedge ref_clk_i);
    digital <= 5'b01010;
    settle(4);
    for (int k = 8; k < 15; k++) begin
      @(posedge ref_clk_i);
      sel_one <= 4'(k);
      settle(2);
      check(16'(pin_one.pin), 16'(rows[k].pin ^ (k != 10 && k != 11)));
    end
    $display("test selector rows done");
    // every group choice, bit zero on pin one
    for (int s = 0; s < 8; s++) begin
      @(posedge ref_clk_i);
      bus_sel <= 3'(s);
      sel_one <= SEL_TEST_BUS;
      settle(4);
      check(16'(bus), s < 4 ? 16'(grp[s]) : 16'h0000);
      check(16'(pin_one.pin), s < 4 ? 16'(grp[s][0]) : 16'h0000);
    end
    $display("test bus done");
    // both generator lengths, checked by their recurrences
    run_prbs(MODE_RAW, 1'b0, 40);
    check(16'(|bits[39:0]), 16'h0001);
    for (int i = 0; i < 31; i++) check(16'(bits[i+9]), 16'(bits[i] ^ bits[i+4]));
    run_prbs(MODE_RAW, 1'b1, 40);
    check(16'(|bits[39:0]), 16'h0001);
    for (int i = 0; i < 25; i++) check(16'(bits[i+15]), 16'(bits[i] ^ bits[i+1]));
    $display("test pattern done");
    // framing: start bit and odd parity, then preamble and sync bytes
    run_prbs(MODE_PARITY, 1'b0, 40);
    for (int f = 0; f < 4; f++) begin
      check(16'(bits[10*f]), 16'h0000);
      check(16'(^bits[10*f+1 +: 9]), 16'h0001);
    end
    run_prbs(MODE_SYNC, 1'b1, 64);
    check(16'(|bits[47:0]), 16'h0000);
    for (int j = 0; j < 16; j++) check(16'(bits[48+j]), 16'(sync_word[15-j]));
    @(posedge ref_clk_i);
    send <= 1'b0;
    settle(8);
    check(16'(tx_valid), 16'h0000);
    $display("test framing done");
    // reset in mid stream
    run_prbs(MODE_RAW, 1'b0, 4);
    @(posedge ref_clk_i);
    sys_rst_i <= 1'b1;
    settle(2);
    check({pin_one.oe_n, pin_two.oe_n, 7'(bus), 7'(tx_valid)}, 16'hC000);
    @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    // stream restarts from a fresh seed with enable and send still held
    settle(1);
    check(16'(tx_valid), 16'h0000);
    settle(5);
    check(16'(tx_valid), 16'h0001);
    $display("test reset done");
    results();
  end
endmodule
